// [ebw_top.sv]
// AXI4-Lite bus width register bank with region access check and transfer count.
`timescale 1ns/1ps
module ebw_top
	import ebw_pkg::*;
#(
	parameter bit SPLIT_IO23 = 1'b0
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic acc_valid,
	input wire logic [1:0] acc_region,
	input wire logic acc_from_dma,
	input wire logic [1:0] acc_size,
	output logic acc_done,
	output logic acc_abort,
	output logic acc_error,
	output logic [2:0] acc_ext_transfers,
	output logic [1:0] rom_region_width,
	output logic [1:0] sram_region_width,
	output logic [1:0] io_bank01_width,
	output logic [1:0] io_bank23_width
);

	////////////////////////////////////////////////////////////////////////////////
	// Write channel holding state.
	// Each channel frees its slot only on the response handshake, so at most one
	// write is ever in flight and the held address and data cannot be overtaken.
	logic [31:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic aw_held;
	logic w_held;
	logic do_write;
	logic wr_main;
	logic wr_sep;
	logic rd_main;
	logic rd_sep;
	logic [31:0] next_rdata;

	// Only the stored fields exist as flops, so reserved bits can never hold a value.
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_main = (aw_addr == EBW_ADDR_REGION_WIDTH);
	assign wr_sep = SPLIT_IO23 && (aw_addr == EBW_ADDR_IO23_WIDTH);
	assign rd_main = (s_axi_araddr == EBW_ADDR_REGION_WIDTH);
	assign rd_sep = SPLIT_IO23 && (s_axi_araddr == EBW_ADDR_IO23_WIDTH);

	// Address and data are taken independently, in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b0;
			aw_addr <= 32'h0000_0000;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_held <= 1'b0;
		end
	end

	// Write data side; the ready stays low until the response is accepted.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_held <= 1'b0;
		end
	end

	// Write response; an address that maps to no register answers SLVERR.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EBW_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_main || wr_sep) ? EBW_RESP_OKAY : EBW_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Width fields; all live in byte lane 0 except the shared bank 2/3 field in lane 1.
	// A width update steers the access check from the next clock onward.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rom_region_width <= EBW_ROM_RESET;
			sram_region_width <= EBW_SRAM_RESET;
			io_bank01_width <= EBW_IO01_RESET;
		end else if (do_write && wr_main && w_strb[0]) begin
			rom_region_width <= w_data[EBW_ROM_LSB +: 2];
			sram_region_width <= w_data[EBW_SRAM_LSB +: 2];
			io_bank01_width <= w_data[EBW_IO01_LSB +: 2];
		end
	end

	// One flop holds the bank 2/3 width; the variant picks which register reaches it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_bank23_width <= EBW_IO23_RESET;
		end else if (do_write && !SPLIT_IO23 && wr_main && w_strb[1]) begin
			io_bank23_width <= w_data[EBW_IO23_MAIN_LSB +: 2];
		end else if (do_write && wr_sep && w_strb[0]) begin
			io_bank23_width <= w_data[EBW_IO23_SEP_LSB +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data assembly; every bit without a field is a constant zero.
	// The decode is an exact match, so any other address answers SLVERR with zero data.
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (rd_main) begin
			next_rdata[EBW_ROM_LSB +: 2] = rom_region_width;
			next_rdata[EBW_SRAM_LSB +: 2] = sram_region_width;
			next_rdata[EBW_IO01_LSB +: 2] = io_bank01_width;
			if (!SPLIT_IO23) begin
				next_rdata[EBW_IO23_MAIN_LSB +: 2] = io_bank23_width;
			end
		end else if (rd_sep) begin
			next_rdata[EBW_IO23_SEP_LSB +: 2] = io_bank23_width;
		end
	end

	// Read channel; the answer comes one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= EBW_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= (rd_main || rd_sep) ? EBW_RESP_OKAY : EBW_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Region access check and external transfer count.
	// The check is a single registered stage: results always appear one clock after the
	// request, whatever the region, so masters may issue a request on every cycle.
	// The count covers the data phase only; wait states and chip-select timing belong
	// to the access timing logic and are not modelled here.
	logic [1:0] sel_width;
	logic sel_is_8;
	logic [2:0] next_transfers;

	// Pick the width of the addressed region.
	always_comb begin
		unique case (ebw_region_t'(acc_region))
			EBW_REGION_ROM: sel_width = rom_region_width;
			EBW_REGION_SRAM: sel_width = sram_region_width;
			EBW_REGION_IO01: sel_width = io_bank01_width;
			EBW_REGION_IO23: sel_width = io_bank23_width;
		endcase
	end

	// The 8-bit code on ROM and SRAM means 8-bit only on the split variant; elsewhere,
	// and for the reserved code, the path falls back to 16-bit since nothing is promised.
	assign sel_is_8 = (sel_width == EBW_WIDTH_8)
		&& (SPLIT_IO23 || acc_region == EBW_REGION_IO01 || acc_region == EBW_REGION_IO23);

	// A narrow region splits a wider internal access into back-to-back transfers.
	always_comb begin
		next_transfers = 3'd1;
		if (acc_size == EBW_SIZE_WORD) begin
			next_transfers = sel_is_8 ? 3'd4 : 3'd2;
		end else if (acc_size == EBW_SIZE_HALF && sel_is_8) begin
			next_transfers = 3'd2;
		end
	end

	// An absent region blocks the access: CPU sees abort, DMA sees error.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_done <= 1'b0;
			acc_abort <= 1'b0;
			acc_error <= 1'b0;
			acc_ext_transfers <= 3'd0;
		end else begin
			acc_done <= acc_valid;
			acc_abort <= acc_valid && !acc_from_dma && (sel_width == EBW_WIDTH_ABSENT);
			acc_error <= acc_valid && acc_from_dma && (sel_width == EBW_WIDTH_ABSENT);
			acc_ext_transfers <= (acc_valid && sel_width != EBW_WIDTH_ABSENT) ? next_transfers : 3'd0;
		end
	end

endmodule : ebw_top

// [ebw_pkg.sv]
// Constants and types for the external bus width control register bank.
// How it works
// - ROM width field bits 3:2, coded decode.
// - ROM absent blocks access, CPU gets abort.
// - SRAM width field bits 5:4, same coding.
// - I/O bank 0/1 width bits 7:6 decoded.
// - Shared-variant I/O bank 2/3 width bits 9:8.
// - Split-variant I/O 2/3 width, own register 7:6.
// - Reserved bits read zero, writes discarded.
// - Full 32-bit read and write access.
package ebw_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam logic [31:0] EBW_ADDR_REGION_WIDTH = 32'h7810_0000;
	localparam logic [31:0] EBW_ADDR_IO23_WIDTH = 32'h7830_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions (low bit of each two-bit field).
	localparam int EBW_ROM_LSB = 2;
	localparam int EBW_SRAM_LSB = 4;
	localparam int EBW_IO01_LSB = 6;
	localparam int EBW_IO23_MAIN_LSB = 8;
	localparam int EBW_IO23_SEP_LSB = 6;

	////////////////////////////////////////////////////////////////////////////////
	// Width codes and reset values.
	localparam logic [1:0] EBW_WIDTH_ABSENT = 2'h0;
	localparam logic [1:0] EBW_WIDTH_8 = 2'h1;
	localparam logic [1:0] EBW_WIDTH_16 = 2'h2;
	localparam logic [1:0] EBW_ROM_RESET = 2'h2;
	localparam logic [1:0] EBW_SRAM_RESET = 2'h0;
	localparam logic [1:0] EBW_IO01_RESET = 2'h0;
	localparam logic [1:0] EBW_IO23_RESET = 2'h0;

	////////////////////////////////////////////////////////////////////////////////
	// AXI response codes.
	localparam logic [1:0] EBW_RESP_OKAY = 2'h0;
	localparam logic [1:0] EBW_RESP_SLVERR = 2'h2;

	// Region selector and internal access size.
	typedef enum logic [1:0] {EBW_REGION_ROM, EBW_REGION_SRAM, EBW_REGION_IO01, EBW_REGION_IO23} ebw_region_t;
	typedef enum logic [1:0] {EBW_SIZE_BYTE, EBW_SIZE_HALF, EBW_SIZE_WORD} ebw_size_t;

endpackage : ebw_pkg

// [ebw_properties.sv]
// Concurrent checks on the bus width register bank ports.
`timescale 1ns/1ps
module ebw_properties (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic acc_valid,
	input wire logic [1:0] acc_region,
	input wire logic acc_from_dma,
	input wire logic [1:0] acc_size,
	input wire logic acc_done,
	input wire logic acc_abort,
	input wire logic acc_error,
	input wire logic [2:0] acc_ext_transfers,
	input wire logic [1:0] rom_region_width,
	input wire logic [1:0] sram_region_width,
	input wire logic [1:0] io_bank01_width,
	input wire logic [1:0] io_bank23_width
);
	logic [1:0] w;
	// Width code of the region named by the request.
	assign w = acc_region[1] ? (acc_region[0] ? io_bank23_width : io_bank01_width)
		: (acc_region[0] ? sram_region_width : rom_region_width);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	// Code 1 is an 8-bit width on the I/O banks in every variant but on ROM and SRAM only when split, so the 4-transfer check stays on the I/O banks.
	done_latency_a: assert property (acc_valid |=> acc_done) else $error("done late");
	idle_quiet_a: assert property (!acc_valid |=> !acc_done && acc_ext_transfers == 3'h0) else $error("idle done");
	cpu_abort_a: assert property (acc_valid && w == 2'h0 && !acc_from_dma |=> acc_abort && !acc_error
		&& acc_ext_transfers == 3'h0) else $error("no abort");
	dma_error_a: assert property (acc_valid && w == 2'h0 && acc_from_dma |=> acc_error && !acc_abort)
		else $error("no error");
	word_narrow_a: assert property (acc_valid && acc_region[1] && w == 2'h1 && acc_size == 2'h2
		|=> acc_ext_transfers == 3'h4) else $error("8-bit split");
	word_wide_a: assert property (acc_valid && w == 2'h2 && acc_size == 2'h2 |=> acc_ext_transfers == 3'h2)
		else $error("16-bit split");
	read_latency_a: assert property (ar_take |=> s_axi_rvalid) else $error("read late");
	read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read dropped");
	reserved_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h0 |-> s_axi_rdata[31:10] == 22'h0
		&& s_axi_rdata[1:0] == 2'h0) else $error("reserved set");
endmodule : ebw_properties
bind ebw_top ebw_properties ebw_properties_inst (.*);

// [ebw_acc_master.sv]
// Model of the CPU and DMA masters that request internal accesses.
`timescale 1ns/1ps
module ebw_acc_master (
	input wire logic aclk,
	output logic acc_valid,
	output logic [1:0] acc_region,
	output logic acc_from_dma,
	output logic [1:0] acc_size
);
	// Quiet lines at time zero.
	initial begin
		acc_valid = 1'b0;
		acc_region = 2'h0;
		acc_from_dma = 1'b0;
		acc_size = 2'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// One request pulse; idle lines show the inverse so a stale value never passes.
	task issue(input logic [1:0] r, input logic d, input logic [1:0] s);
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc_region <= r;
		acc_from_dma <= d;
		acc_size <= s;
		@(posedge aclk);
		acc_valid <= 1'b0;
		acc_region <= ~r;
		acc_from_dma <= ~d;
		acc_size <= ~s;
	endtask : issue
endmodule : ebw_acc_master

// [tb.sv]
// Self-checking bench for the bus width register bank.
`timescale 1ns/1ps
module tb;
	import ebw_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, acc_valid, acc_from_dma;
	logic acc_done, acc_abort, acc_error;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [2:0] acc_ext_transfers;
	logic [1:0] s_axi_bresp, s_axi_rresp, acc_region, acc_size, rs;
	logic [1:0] rom_region_width, sram_region_width, io_bank01_width, io_bank23_width;
	int bad_count = 0;
	int total_checks = 0;
	ebw_top ebw_top_inst (.*);
	ebw_acc_master ebw_acc_master_inst (.*);
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
			bad_count++;
		end
	endtask : chk
	////////////////////////////////////////////////////////////////////////////////
	// Bus tasks hold each channel until its own handshake edge.
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task rdr(input logic [31:0] a);
		@(posedge aclk);
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask : rdr
	// Result word is {done, abort, error, transfers}, settled just after the answer edge.
	task ac(input logic [1:0] r, input logic d, input logic [1:0] s, input logic [5:0] e);
		ebw_acc_master_inst.issue(r, d, s);
		#1;
		chk(32'({acc_done, acc_abort, acc_error, acc_ext_transfers}), 32'(e));
	endtask : ac
	////////////////////////////////////////////////////////////////////////////////
	task t_reset;
		rdr(EBW_ADDR_REGION_WIDTH);
		chk(rd, 32'h0000_0008);
		chk(32'(rs), 32'(EBW_RESP_OKAY));
		ac(2'h0, 1'b0, 2'h2, 6'h22);
		ac(2'h1, 1'b0, 2'h0, 6'h30);
	endtask : t_reset
	// Reserved bits written as ones; fields set to legal codes only.
	task t_widths;
		wr(EBW_ADDR_REGION_WIDTH, 32'hFFFF_FE6B);
		chk(32'(rs), 32'(EBW_RESP_OKAY));
		rdr(EBW_ADDR_REGION_WIDTH);
		chk(rd, 32'h0000_0268);
		chk(32'({io_bank01_width, io_bank23_width}), 32'h0000_0006);
		chk(32'({rom_region_width, sram_region_width}), 32'h0000_000A);
		ac(2'h2, 1'b0, 2'h2, 6'h24);
		ac(2'h2, 1'b1, 2'h1, 6'h22);
		ac(2'h3, 1'b0, 2'h2, 6'h22);
		ac(2'h1, 1'b1, 2'h0, 6'h21);
	endtask : t_widths
	task t_absent;
		wr(EBW_ADDR_REGION_WIDTH, 32'h0000_0000);
		ac(2'h0, 1'b0, 2'h0, 6'h30);
		ac(2'h1, 1'b1, 2'h2, 6'h28);
		ac(2'h2, 1'b1, 2'h2, 6'h28);
		ac(2'h3, 1'b1, 2'h0, 6'h28);
	endtask : t_absent
	task t_unmapped;
		wr(EBW_ADDR_IO23_WIDTH, 32'hFFFF_FFFF);
		chk(32'(rs), 32'(EBW_RESP_SLVERR));
		rdr(EBW_ADDR_REGION_WIDTH);
		chk(rd, 32'h0000_0000);
		rdr(EBW_ADDR_IO23_WIDTH);
		chk(rd, 32'h0000_0000);
		chk(32'(rs), 32'(EBW_RESP_SLVERR));
	endtask : t_unmapped
	// Lane 1 alone reaches the bank 2/3 field; lane 0 fields keep their values.
	task t_lanes;
		s_axi_wstrb <= 4'h2;
		wr(EBW_ADDR_REGION_WIDTH, 32'h0000_01FC);
		s_axi_wstrb <= 4'hF;
		rdr(EBW_ADDR_REGION_WIDTH);
		chk(rd, 32'h0000_0100);
		ac(2'h3, 1'b1, 2'h2, 6'h24);
	endtask : t_lanes
	task finish_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	// Reset for 20 cycles, then the scenarios in order.
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {96'h0, 4'hF};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_widths;
		t_absent;
		t_unmapped;
		t_lanes;
		finish_test;
	end
	// The whole run needs under a hundred cycles; this bound only cuts a hang.
	initial begin
		repeat (5000) @(posedge aclk);
		bad_count++;
		finish_test;
	end
endmodule : tb
